/* pkg/tdc_pkg.sv */
// shared constants, types and helpers for the trim dac connect and track controller
package tdc_pkg;

   // ----------------------------------------------------------------
   // register indices on the register port
   // ----------------------------------------------------------------
   localparam logic [2:0] IDX_CTRL_CH0 = 3'h0;
   localparam logic [2:0] IDX_CTRL_CH1 = 3'h1;
   localparam logic [2:0] IDX_TGT_CH0 = 3'h2;
   localparam logic [2:0] IDX_TGT_CH1 = 3'h3;
   localparam logic [2:0] IDX_DLY_CH0 = 3'h4;
   localparam logic [2:0] IDX_DLY_CH1 = 3'h5;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int BIT_EN = 8;
   localparam int BIT_CON = 9;
   localparam int BIT_POL = 10;
   localparam int BIT_REP = 11;
   localparam int BIT_TRK_EN = 8;
   localparam int DLY_W = 10;
   localparam logic [7:0] CODE_RESET = 8'h00;
   localparam logic [7:0] CODE_MID = 8'h80;
   localparam logic [7:0] CODE_MIN = 8'h00;
   localparam logic [7:0] CODE_MAX = 8'hff;
   localparam logic [9:0] DLY_RESET = 10'h000;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int STEP_PERIOD_NS = 1000;
   localparam int STEP_CYC = (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {SC_IDLE, SC_WAIT, SC_SEARCH} tdc_sc_t;

   // one code step with clamping at both ends, never wraps
   function automatic logic [7:0] tdc_step(input logic [7:0] code, input logic up);
      if (up) begin
         return (code == CODE_MAX) ? CODE_MAX : code + 8'h01;
      end else begin
         return (code == CODE_MIN) ? CODE_MIN : code - 8'h01;
      end
   endfunction

endpackage

/* design/tdc_ramp.sv */
// per-channel tracking ramp: start delay then one code step per tick
`timescale 1ns/10ps
module tdc_ramp import tdc_pkg::*; #(
   parameter int DW = DLY_W
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // control
   input wire logic tick,
   input wire logic start,
   input wire logic allow,
   input wire logic [DW-1:0] delay,
   input wire logic [7:0] target,
   input wire logic [7:0] code,
   // step requests
   output logic step_up,
   output logic step_down,
   output logic busy
);

   logic [DW-1:0] dly_cnt;
   logic [DW-1:0] next_dly_cnt;
   logic next_busy;

   always_comb begin
      next_busy = busy;
      next_dly_cnt = dly_cnt;
      if (start && allow) begin
         next_busy = 1'b1;
         next_dly_cnt = delay;
      end else if (!allow) begin
         next_busy = 1'b0;
      end else if (busy && tick) begin
         if (dly_cnt != '0) begin
            next_dly_cnt = dly_cnt - 1'b1;
         end else if (code == target) begin
            next_busy = 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         busy <= 1'b0;
         dly_cnt <= '0;
      end else begin
         busy <= next_busy;
         dly_cnt <= next_dly_cnt;
      end
   end

   // steps only after the delay has run out, one per tick
   assign step_up = busy && allow && tick && (dly_cnt == '0) && (code < target);
   assign step_down = busy && allow && tick && (dly_cnt == '0) && (code > target);

endmodule // tdc_ramp

/* design/tdc_ctrl.sv */
// two-channel trim dac connect, servo and tracking control
//
// What this block does
// - Control register low byte holds the trim code driving each dac current.
// - Enable bit zero leaves output pin undriven; one connects soft or hard.
// - Enable with connected bit low runs a search until comparator matches.
// - Enable with connected bit high attaches the buffer at once.
// - Connected bit reads zero after reset, while disabled or still searching.
// - Connected bit reads one once the buffer is attached.
// - Repeat off: servo stops at the first step that finds the result at target.
// - Repeat on: servo keeps regulating toward target without stopping.
// - Tracking steps the code by one per step until it equals target.
// - Tracking enable bit allows tracking when one, inhibits when zero.
// - A ten-bit delay per channel offsets the start of tracking.
// - Soft connect ignores written code and starts the search at midscale.
// - Search reaching either end without trip fails, flags fault, stays detached.
// - Writing connected bit zero never detaches; only clearing enable does.
`timescale 1ns/10ps
module tdc_ctrl import tdc_pkg::*; #(
   parameter int STEP_CYCLES = STEP_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [2:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   // analog side status
   input wire logic [1:0] comp_level,
   input wire logic [1:0] servo_en,
   input wire logic [1:0] servo_raise,
   input wire logic [1:0] servo_at_target,
   input wire logic track_start,
   // dac and buffer controls
   output logic [7:0] trim_code_ch0,
   output logic [7:0] trim_code_ch1,
   output logic [1:0] buffer_attach,
   output logic [1:0] dac_fault
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] code [2];
   logic [7:0] next_code [2];
   logic [7:0] tgt [2];
   logic [7:0] next_tgt [2];
   logic [DLY_W-1:0] dly [2];
   logic [DLY_W-1:0] next_dly [2];
   tdc_sc_t sc [2];
   tdc_sc_t next_sc [2];
   logic [1:0] en, con, pol, rep, fault, ref_lvl, hold, trk_en;
   logic [1:0] next_en, next_con, next_pol, next_rep, next_fault;
   logic [1:0] next_ref_lvl, next_hold, next_trk_en;
   logic [15:0] tick_cnt;
   logic [15:0] next_tick_cnt;
   logic tick;
   logic [15:0] next_rdata;
   logic [1:0] step_up, step_dn;

   // ----------------------------------------------------------------
   // step pacing: searches, servo and ramps all move at one step rate
   // ----------------------------------------------------------------
   assign tick = (tick_cnt == 16'(STEP_CYCLES - 1));
   assign next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;

   // ----------------------------------------------------------------
   // tracking ramps
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_ramp
      tdc_ramp #(.DW(DLY_W)) u_ramp (
         .clock(clock),
         .rst_n(rst_n),
         .tick(tick),
         .start(track_start),
         .allow(trk_en[g]),
         .delay(dly[g]),
         .target(tgt[g]),
         .code(code[g]),
         .step_up(step_up[g]),
         .step_down(step_dn[g]),
         .busy()
      );
   end

   // ----------------------------------------------------------------
   // channel next state
   // ----------------------------------------------------------------
   always_comb begin
      next_code = code;
      next_tgt = tgt;
      next_dly = dly;
      next_sc = sc;
      next_en = en;
      next_con = con;
      next_pol = pol;
      next_rep = rep;
      next_fault = fault;
      next_ref_lvl = ref_lvl;
      next_hold = hold;
      next_trk_en = trk_en;
      for (int ch = 0; ch < 2; ch++) begin
         // connect search, channel 0 wins the shared search engine
         if (sc[ch] == SC_WAIT) begin
            if ((ch == 0) ? (sc[1] != SC_SEARCH) : (sc[0] == SC_IDLE)) begin
               next_sc[ch] = SC_SEARCH;
               next_ref_lvl[ch] = comp_level[ch];
            end
         end else if (sc[ch] == SC_SEARCH && tick) begin
            if (comp_level[ch] != ref_lvl[ch]) begin
               next_con[ch] = 1'b1;
               next_sc[ch] = SC_IDLE;
            end else if (code[ch] == CODE_MIN || code[ch] == CODE_MAX) begin
               next_fault[ch] = 1'b1;
               next_sc[ch] = SC_IDLE;
            end else begin
               next_code[ch] = tdc_step(code[ch], !ref_lvl[ch]);
            end
         end
         // servo takes precedence over tracking once attached
         if (!servo_en[ch] || rep[ch]) begin
            next_hold[ch] = 1'b0;
         end
         if (con[ch] && servo_en[ch] && tick) begin
            if (servo_at_target[ch]) begin
               next_hold[ch] = !rep[ch];
            end else if (!hold[ch]) begin
               next_code[ch] = tdc_step(code[ch], servo_raise[ch] ~^ pol[ch]);
            end
         end else if (con[ch] && (step_up[ch] || step_dn[ch])) begin
            next_code[ch] = tdc_step(code[ch], step_up[ch]);
         end
      end
      // register writes override the engines in the same cycle
      if (reg_wr) begin
         for (int ch = 0; ch < 2; ch++) begin
            if (reg_addr == (ch == 0 ? IDX_CTRL_CH0 : IDX_CTRL_CH1)) begin
               if (!reg_wdata[BIT_EN]) begin
                  next_en[ch] = 1'b0;
                  next_con[ch] = 1'b0;
                  next_sc[ch] = SC_IDLE;
                  next_fault[ch] = 1'b0;
                  next_rep[ch] = reg_wdata[BIT_REP];
                  next_code[ch] = reg_wdata[7:0];
                  next_pol[ch] = reg_wdata[BIT_POL];
               end else if (sc[ch] != SC_IDLE || fault[ch]) begin
                  next_en[ch] = en[ch];
               end else if (!en[ch] && reg_wdata[BIT_CON]) begin
                  next_en[ch] = 1'b1;
                  next_con[ch] = 1'b1;
                  next_code[ch] = reg_wdata[7:0];
                  next_pol[ch] = reg_wdata[BIT_POL];
                  next_rep[ch] = reg_wdata[BIT_REP];
               end else if (!en[ch]) begin
                  next_en[ch] = 1'b1;
                  next_con[ch] = 1'b0;
                  next_code[ch] = CODE_MID;
                  next_sc[ch] = SC_WAIT;
                  next_pol[ch] = reg_wdata[BIT_POL];
                  next_rep[ch] = reg_wdata[BIT_REP];
               end else begin
                  // already attached: connected bit stays set whatever is written
                  next_rep[ch] = reg_wdata[BIT_REP];
                  if (!servo_en[ch]) begin
                     next_code[ch] = reg_wdata[7:0];
                     next_pol[ch] = reg_wdata[BIT_POL];
                  end
               end
            end else if (reg_addr == (ch == 0 ? IDX_TGT_CH0 : IDX_TGT_CH1)) begin
               next_tgt[ch] = reg_wdata[7:0];
               next_trk_en[ch] = reg_wdata[BIT_TRK_EN];
            end else if (reg_addr == (ch == 0 ? IDX_DLY_CH0 : IDX_DLY_CH1)) begin
               next_dly[ch] = reg_wdata[DLY_W-1:0];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // read mux, unmapped indices and reserved bits read zero
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = 16'h0000;
      if (reg_addr == IDX_CTRL_CH0) begin
         next_rdata = {4'h0, rep[0], pol[0], con[0], en[0], code[0]};
      end else if (reg_addr == IDX_CTRL_CH1) begin
         next_rdata = {4'h0, rep[1], pol[1], con[1], en[1], code[1]};
      end else if (reg_addr == IDX_TGT_CH0) begin
         next_rdata = {7'h00, trk_en[0], tgt[0]};
      end else if (reg_addr == IDX_TGT_CH1) begin
         next_rdata = {7'h00, trk_en[1], tgt[1]};
      end else if (reg_addr == IDX_DLY_CH0) begin
         next_rdata = {6'h00, dly[0]};
      end else if (reg_addr == IDX_DLY_CH1) begin
         next_rdata = {6'h00, dly[1]};
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         for (int ch = 0; ch < 2; ch++) begin
            code[ch] <= CODE_RESET;
            tgt[ch] <= CODE_RESET;
            dly[ch] <= DLY_RESET;
            sc[ch] <= SC_IDLE;
         end
         en <= 2'h0;
         con <= 2'h0;
         pol <= 2'h0;
         rep <= 2'h0;
         fault <= 2'h0;
         ref_lvl <= 2'h0;
         hold <= 2'h0;
         trk_en <= 2'h0;
         tick_cnt <= 16'h0000;
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         code <= next_code;
         tgt <= next_tgt;
         dly <= next_dly;
         sc <= next_sc;
         en <= next_en;
         con <= next_con;
         pol <= next_pol;
         rep <= next_rep;
         fault <= next_fault;
         ref_lvl <= next_ref_lvl;
         hold <= next_hold;
         trk_en <= next_trk_en;
         tick_cnt <= next_tick_cnt;
         reg_rdata <= reg_rd ? next_rdata : reg_rdata;
         reg_rvalid <= reg_rd;
      end
   end

   // pin drive follows the connected flag, so the pin floats until attached
   assign trim_code_ch0 = code[0];
   assign trim_code_ch1 = code[1];
   assign buffer_attach = con;
   assign dac_fault = fault;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_soft_mid;
      @(posedge clock) disable iff (!rst_n)
      (reg_wr && reg_addr == IDX_CTRL_CH0 && reg_wdata[BIT_EN] && !reg_wdata[BIT_CON]
         && !en[0] && sc[0] == SC_IDLE && !fault[0])
      |=> (code[0] == CODE_MID) && !con[0] && (sc[0] == SC_WAIT);
   endproperty
   a_soft_mid: assert property (p_soft_mid) else $error("soft connect not at midscale");

   property p_hard;
      @(posedge clock) disable iff (!rst_n)
      (reg_wr && reg_addr == IDX_CTRL_CH1 && reg_wdata[BIT_EN] && reg_wdata[BIT_CON]
         && !en[1] && sc[1] == SC_IDLE && !fault[1])
      |=> con[1] && buffer_attach[1] && (code[1] == $past(reg_wdata[7:0]));
   endproperty
   a_hard: assert property (p_hard) else $error("hard connect did not attach");

   property p_disable;
      @(posedge clock) disable iff (!rst_n)
      (reg_wr && reg_addr == IDX_CTRL_CH1 && !reg_wdata[BIT_EN]) |=> !con[1] && !en[1];
   endproperty
   a_disable: assert property (p_disable) else $error("disable left channel attached");

   property p_keep_attached;
      @(posedge clock) disable iff (!rst_n)
      (con[1] && reg_wr && reg_addr == IDX_CTRL_CH1 && reg_wdata[BIT_EN]
         && !reg_wdata[BIT_CON]) |=> con[1];
   endproperty
   a_keep_attached: assert property (p_keep_attached) else $error("attach lost");

   property p_con_needs_en;
      @(posedge clock) disable iff (!rst_n)
      con[1] |-> en[1] && (sc[1] == SC_IDLE);
   endproperty
   a_con_needs_en: assert property (p_con_needs_en) else $error("attached while off");

   property p_fail;
      @(posedge clock) disable iff (!rst_n)
      (sc[1] == SC_SEARCH && tick && comp_level[1] == ref_lvl[1]
         && (code[1] == CODE_MIN || code[1] == CODE_MAX) && !reg_wr)
      |=> fault[1] && !con[1] && (sc[1] == SC_IDLE);
   endproperty
   a_fail: assert property (p_fail) else $error("failed search not flagged");

   property p_one_step;
      @(posedge clock) disable iff (!rst_n)
      (!reg_wr && sc[1] != SC_WAIT) |=> (code[1] == $past(code[1]))
         || (code[1] == $past(code[1]) + 8'h01) || (code[1] == $past(code[1]) - 8'h01);
   endproperty
   a_one_step: assert property (p_one_step) else $error("code moved more than one");

   property p_hold;
      @(posedge clock) disable iff (!rst_n)
      (hold[0] && servo_en[0] && !rep[0] && !reg_wr)[*2] |-> $stable(code[0]);
   endproperty
   a_hold: assert property (p_hold) else $error("servo moved after settling");

   property p_reserved;
      @(posedge clock) disable iff (!rst_n)
      (reg_rd && reg_addr == IDX_DLY_CH0) |=> reg_rvalid && (reg_rdata[15:10] == 6'h00);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

endmodule // tdc_ctrl

/* test/tdc_analog_model.sv */
// feedback node, comparator and servo measurement model facing both trim channels
`timescale 1ns/10ps
module tdc_analog_model import tdc_pkg::*; (
   // dac codes and programmed polarity
   input wire logic [7:0] trim_code_ch0,
   input wire logic [7:0] trim_code_ch1,
   input wire logic [1:0] pol,
   // scenario settings
   input wire logic [1:0] stuck,
   input wire logic [7:0] pin_code_ch0,
   input wire logic [7:0] pin_code_ch1,
   input wire logic [8:0] servo_tgt_ch0,
   input wire logic [8:0] servo_tgt_ch1,
   // comparator and servo status
   output logic [1:0] comp_level,
   output logic [1:0] servo_raise,
   output logic [1:0] servo_at_target
);
   logic [8:0] code [2];
   logic [8:0] pin [2];
   logic [8:0] tgt [2];
   always_comb begin
      code[0] = {1'b0, trim_code_ch0};
      code[1] = {1'b0, trim_code_ch1};
      pin[0] = {1'b0, pin_code_ch0};
      pin[1] = {1'b0, pin_code_ch1};
      tgt[0] = servo_tgt_ch0;
      tgt[1] = servo_tgt_ch1;
      for (int i = 0; i < 2; i++) begin
         // a stuck comparator never trips, so a search runs to an end of the range
         comp_level[i] = !stuck[i] && (code[i] >= pin[i]);
         servo_at_target[i] = (code[i] == tgt[i]);
         // pol low is the inverting arrangement: a higher code gives a lower result
         servo_raise[i] = pol[i] ? (code[i] < tgt[i]) : (code[i] > tgt[i]);
      end
   end
endmodule // tdc_analog_model

/* test/testbench.sv */
// self-checking bench for the trim dac connect and track controller
`timescale 1ns/10ps
module testbench import tdc_pkg::*;;
   logic clock, rst_n, reg_wr, reg_rd, reg_rvalid, track_start;
   logic [2:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic [1:0] comp_level, servo_en, servo_raise, servo_at_target;
   logic [1:0] buffer_attach, dac_fault, pol, stuck;
   logic [7:0] trim_code_ch0, trim_code_ch1, pin0, pin1;
   logic [8:0] tgt0, tgt1;
   logic [15:0] exp_q [$];
   int failures, n_tests, cycles, seed;
   // ----------------------------------------------------------------
   // design and far side
   // ----------------------------------------------------------------
   tdc_ctrl #(.STEP_CYCLES(4)) DUT (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .comp_level(comp_level), .servo_en(servo_en),
      .servo_raise(servo_raise), .servo_at_target(servo_at_target),
      .track_start(track_start), .trim_code_ch0(trim_code_ch0),
      .trim_code_ch1(trim_code_ch1), .buffer_attach(buffer_attach), .dac_fault(dac_fault));
   tdc_analog_model u_model (.trim_code_ch0(trim_code_ch0), .trim_code_ch1(trim_code_ch1),
      .pol(pol), .stuck(stuck), .pin_code_ch0(pin0), .pin_code_ch1(pin1),
      .servo_tgt_ch0(tgt0), .servo_tgt_ch1(tgt1), .comp_level(comp_level),
      .servo_raise(servo_raise), .servo_at_target(servo_at_target));
   // ----------------------------------------------------------------
   // clock, timeout and read monitor
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic wrap_up();
      if (failures == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // the oldest note belongs to the oldest read, reads answer in order
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         wrap_up();
      end
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) cmp(reg_rdata, 16'hxxxx);
         else cmp(reg_rdata, exp_q.pop_front());
      end
   end
   // ----------------------------------------------------------------
   // register port and watch helpers
   // ----------------------------------------------------------------
   task automatic wr(input logic [2:0] a, input logic [15:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] v);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(v);
      @(posedge clock);
      reg_rd <= 1'b0;
   endtask
   function automatic logic [15:0] look(input int sel);
      case (sel)
         0: return {8'h00, trim_code_ch0};
         1: return {8'h00, trim_code_ch1};
         2: return {14'h0000, buffer_attach};
         default: return {14'h0000, dac_fault};
      endcase
   endfunction
   // bounded wait: a value that never arrives shows up as a mismatch
   task automatic wait_sig(input int sel, input logic [15:0] v, input int lim);
      int k;
      k = 0;
      while (look(sel) !== v && k < lim) begin
         @(posedge clock);
         k++;
      end
      cmp(look(sel), v);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_n, reg_wr, reg_rd, track_start, reg_addr, reg_wdata} = '0;
      {servo_en, pol, stuck, tgt0, tgt1} = '0;
      failures = 0;
      n_tests = 0;
      cycles = 0;
      seed = 52351;
      pin0 = 8'h88;
      pin1 = 8'h7c;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) rd(3'(i), 16'h0000);
      for (int i = 2; i < 8; i++) begin
         d = 16'($random(seed));
         wr(3'(i), d);
         rd(3'(i), d & (i < 4 ? 16'h01ff : i < 6 ? 16'h03ff : 16'h0000));
      end
      wr(IDX_CTRL_CH0, 16'hfec3);
      rd(IDX_CTRL_CH0, 16'h0cc3);
      wait_sig(0, 16'h00c3, 3);
      cmp(look(2), 16'h0000);
      wr(IDX_CTRL_CH0, 16'h0000);
      // soft connect both channels, ch1 queued behind ch0
      wr(IDX_CTRL_CH0, 16'h0133);
      wait_sig(0, 16'h0080, 3);
      cmp(look(2), 16'h0000);
      wr(IDX_CTRL_CH1, 16'h0155);
      wait_sig(2, 16'h0003, 400);
      rd(IDX_CTRL_CH0, 16'h0388);
      rd(IDX_CTRL_CH1, 16'h037b);
      // tracking ramp on ch0 only, after its start delay
      wr(IDX_TGT_CH0, 16'h018c);
      wr(IDX_DLY_CH0, 16'h000a);
      wr(IDX_TGT_CH1, 16'h0070);
      @(posedge clock);
      track_start <= 1'b1;
      @(posedge clock);
      track_start <= 1'b0;
      repeat (30) @(posedge clock);
      cmp(look(0), 16'h0088);
      wait_sig(0, 16'h008c, 200);
      repeat (20) @(posedge clock);
      cmp(look(0), 16'h008c);
      cmp(look(1), 16'h007b);
      // servo: ch0 non-inverting with repeat, ch1 inverting without
      wr(IDX_CTRL_CH0, 16'h0f8c);
      @(posedge clock);
      pol <= 2'b01;
      tgt0 <= 9'h095;
      tgt1 <= 9'h070;
      servo_en <= 2'b11;
      wait_sig(0, 16'h0095, 200);
      wait_sig(1, 16'h0070, 200);
      @(posedge clock);
      tgt0 <= 9'h090;
      wait_sig(0, 16'h0090, 200);
      @(posedge clock);
      tgt0 <= 9'h100;
      wait_sig(0, 16'h00ff, 600);
      repeat (40) @(posedge clock);
      cmp(look(0), 16'h00ff);
      wr(IDX_CTRL_CH0, 16'h0311);
      rd(IDX_CTRL_CH0, 16'h07ff);
      tgt0 <= 9'h0fa;
      wait_sig(0, 16'h00fa, 200);
      repeat (40) @(posedge clock);
      cmp(look(0), 16'h00fa);
      cmp(look(1), 16'h0070);
      servo_en <= 2'b00;
      // hard connect, stray connected-bit clear, disconnect
      wr(IDX_CTRL_CH1, 16'h0000);
      wait_sig(2, 16'h0001, 3);
      wr(IDX_CTRL_CH1, 16'h0340);
      wait_sig(2, 16'h0003, 3);
      cmp(look(1), 16'h0040);
      wr(IDX_CTRL_CH1, 16'h0140);
      repeat (3) @(posedge clock);
      cmp(look(2), 16'h0003);
      rd(IDX_CTRL_CH1, 16'h0340);
      wr(IDX_CTRL_CH1, 16'h0000);
      wait_sig(2, 16'h0001, 3);
      // a search that never trips ends in a fault
      stuck <= 2'b10;
      wr(IDX_CTRL_CH1, 16'h0155);
      wait_sig(3, 16'h0002, 700);
      cmp(look(2), 16'h0001);
      wr(IDX_CTRL_CH1, 16'h0340);
      rd(IDX_CTRL_CH1, 16'h01ff);
      wr(IDX_CTRL_CH1, 16'h0000);
      wait_sig(3, 16'h0000, 3);
      repeat (4) @(posedge clock);
      cmp(16'(exp_q.size()), 16'h0000);
      wrap_up();
   end
endmodule // testbench
